// >>> shared/epbg_defs.svh
// constants of the off-chip access unit: offsets, fields, reset values
`ifndef EPBG_DEFS_SVH
`define EPBG_DEFS_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define EPBG_OFF_CFG        8'h00
`define EPBG_OFF_START      8'h18
`define EPBG_OFF_CTRL       8'h28
`define EPBG_OFF_STATUS     8'h2C
`define EPBG_REG_STEP       4

// ==========================================================
// per-space config fields
`define EPBG_F_RWAIT        3:0
`define EPBG_F_WWAIT        7:4
`define EPBG_F_ACKMODE      8
`define EPBG_F_DIV          10:9
`define EPBG_F_WHOLD        11
`define EPBG_F_POL          12
`define EPBG_F_WIDE         13
`define EPBG_CFG_RST        16'h2077
`define EPBG_CTRL_EXCL      0

// ==========================================================
// targets and page limits
`define EPBG_NUM_SPACES     6
`define EPBG_NUM_BANKS      4
`define EPBG_T_IO           3'h4
`define EPBG_T_BOOT         3'h5
`define EPBG_T_NONE         3'h7
`define EPBG_IO_FIRST       8'h20
`define EPBG_BOOT_PAGES     8'hFE
`define EPBG_MEM_LAST       8'hFE
`define EPBG_START_RST      32'hC0804001

`endif

// >>> shared/epbg_pkg.sv
// types shared by the off-chip access unit
package epbg_pkg;
   typedef enum logic [1:0] {
      EPBG_IDLE   = 2'h0,
      EPBG_STROBE = 2'h1,
      EPBG_HOLD   = 2'h3,
      EPBG_NEXT   = 2'h2
   } epbg_state_e;
   typedef enum logic [1:0] {
      EPBG_SP_MEM  = 2'h0,
      EPBG_SP_IO   = 2'h1,
      EPBG_SP_BOOT = 2'h2
   } epbg_space_e;
   typedef logic [15:0] epbg_cfg_t;
endpackage

// >>> shared/epbg_arb_if.sv
// link between the access engine and the bus arbiter
`timescale 1ns/1ps
interface epbg_arb_if;
   logic int_pending;
   logic hold_bus;
   logic idle;
   logic granted;
   logic grant_pin_n;
   modport arb (input int_pending, input hold_bus, input idle, output granted, output grant_pin_n);
   modport ctl (output int_pending, output hold_bus, output idle, input granted, input grant_pin_n);
endinterface

// >>> rtl/epbg_arb.sv
// bus request / grant arbiter, alive while the system reset is held
`timescale 1ns/1ps
`include "epbg_defs.svh"
module epbg_arb (
   input  wire logic clk_sys,
   input  wire logic por_n,
   input  wire logic ext_bus_request_n,
   output logic      ext_bus_grant_n,
   output logic      port_drive_en,
   epbg_arb_if.arb   a
);
   import epbg_pkg::*;
   logic req_s1;
   logic req_s2;
   logic pin_pre;

   // ==========================================================
   // request synchroniser
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= ~ext_bus_request_n;
         req_s2 <= req_s1;
      end
   end

   // ==========================================================
   // arbitration: outside master is lowest priority
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         a.granted <= 1'b0;
      end else if (!a.granted) begin
         a.granted <= req_s2 && !a.int_pending && a.idle && !a.hold_bus;
      end else if (!req_s2) begin
         a.granted <= 1'b0;
      end
   end

   // drivers go off one cycle before the grant pin falls, back on after it rises
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         pin_pre         <= 1'b0;
         ext_bus_grant_n <= 1'b1;
         port_drive_en   <= 1'b1;
      end else begin
         pin_pre         <= a.granted;
         ext_bus_grant_n <= ~pin_pre;
         port_drive_en   <= ~a.granted & ext_bus_grant_n;
      end
   end
   assign a.grant_pin_n = ext_bus_grant_n;

   // ==========================================================
   // checks
   sequence s_req_gone;
      a.granted && !req_s2;
   endsequence
   property p_grant_after_sync;
      @(posedge clk_sys) disable iff (!por_n)
      $rose(a.granted) |-> $past(req_s2) && $past(req_s1, 2);
   endproperty
   a_grant_after_sync: assert property (p_grant_after_sync) else $error("grant without synchronised request");
   property p_off_before_grant;
      @(posedge clk_sys) disable iff (!por_n)
      $fell(ext_bus_grant_n) |-> !port_drive_en && $past(!port_drive_en);
   endproperty
   a_off_before_grant: assert property (p_off_before_grant) else $error("grant while port driven");
   property p_grant_idle;
      @(posedge clk_sys) disable iff (!por_n)
      $rose(a.granted) |-> $past(!a.int_pending && a.idle && !a.hold_bus);
   endproperty
   a_grant_idle: assert property (p_grant_idle) else $error("grant over internal request");
   property p_release;
      @(posedge clk_sys) disable iff (!por_n)
      s_req_gone |=> !a.granted ##2 ext_bus_grant_n ##1 port_drive_en;
   endproperty
   a_release: assert property (p_release) else $error("grant not released");
endmodule // epbg_arb

// >>> rtl/epbg_top.sv
// off-chip access unit: space decode, strobes, packing and bus grant
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "epbg_defs.svh"
module epbg_top (
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   input  wire logic               por_n,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [15:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic [15:0]             reg_rdata,
   input  wire logic               req_valid,
   input  wire logic               req_write,
   input  wire epbg_pkg::epbg_space_e req_space,
   input  wire logic [7:0]         req_page,
   input  wire logic [15:0]        req_offset,
   input  wire logic               req_wide,
   input  wire logic [23:0]        req_wdata,
   input  wire logic               req_chain,
   input  wire logic               req_chain_rd,
   output logic                    req_ack,
   output logic                    resp_valid,
   output logic                    resp_err,
   output logic [23:0]             resp_rdata,
   output logic [19:0]             ext_addr,
   output logic [15:0]             ext_data_out,
   input  wire logic [15:0]        ext_data_in,
   output logic                    ext_data_oe,
   output logic                    ext_rd_n,
   output logic                    ext_wr_n,
   output logic                    port_drive_en,
   output logic [3:0]              bank_strobe_n,
   output logic                    io_space_strobe_n,
   output logic                    boot_space_strobe_n,
   input  wire logic               ext_ready,
   input  wire logic               ext_bus_request_n,
   output logic                    ext_bus_grant_n,
   output logic                    grant_hang_n
);
   import epbg_pkg::*;

   // ==========================================================
   // declarations
   epbg_arb_if a ();
   epbg_cfg_t   cfg [`EPBG_NUM_SPACES];
   epbg_cfg_t   cur;
   logic [31:0] start_pg;
   logic        excl;
   epbg_state_e state;
   logic [2:0]  tgt;
   logic [2:0]  req_tgt;
   logic [1:0]  beat;
   logic [1:0]  last_beat;
   logic [3:0]  cnt;
   logic [2:0]  div_cnt;
   logic [2:0]  div_lim;
   logic        tick;
   logic        is_wr;
   logic [23:0] wbuf;
   logic [23:0] rbuf;
   logic [19:0] base;
   logic [19:0] phys;
   logic [5:0]  pol_vec;
   logic [5:0]  strobe_on;
   logic [5:0]  strobe_pin;
   logic        go;
   logic        chain_q;
   logic        hold_bus;
   logic        rdy_s1;
   logic        rdy_s2;
   logic [15:0] din_s1;
   logic [15:0] din_s2;
   logic [15:0] rd_mux;
   logic        wide_q;
   logic        bus_away;

   // ==========================================================
   // functions
   function automatic logic [2:0] decode_space(input epbg_space_e sp, input logic [7:0] pg,
                                               input logic [31:0] st);
      logic [2:0] t;
      t = `EPBG_T_NONE;
      case (sp)
         EPBG_SP_IO: begin
            if (pg >= `EPBG_IO_FIRST) t = `EPBG_T_IO;
         end
         EPBG_SP_BOOT: begin
            if (pg < `EPBG_BOOT_PAGES) t = `EPBG_T_BOOT;
         end
         EPBG_SP_MEM: begin
            // highest bank whose start page is reached owns the page
            if (pg != 8'h00 && pg <= `EPBG_MEM_LAST) begin
               for (int i = 0; i < `EPBG_NUM_BANKS; i++) begin
                  if (pg >= st[8*i +: 8]) t = 3'(i);
               end
            end
         end
         default: t = `EPBG_T_NONE;
      endcase
      return t;
   endfunction

   // one bus lane for beat k; byte-wide beats use the low lane
   function automatic logic [15:0] lane(input logic [23:0] d, input logic [1:0] k, input logic wide);
      logic [23:0] sh;
      sh = wide ? (d >> {k, 4'h0}) : (d >> {k, 3'h0});
      return wide ? sh[15:0] : {8'h00, sh[7:0]};
   endfunction

   function automatic logic [1:0] last_beat_q();
      return cur[`EPBG_F_WIDE] ? {1'b0, wide_q} : (wide_q ? 2'h2 : 2'h1);
   endfunction

   // ==========================================================
   // arbiter
   epbg_arb u_arb (
      .clk_sys           (clk_sys),
      .por_n             (por_n),
      .ext_bus_request_n (ext_bus_request_n),
      .ext_bus_grant_n   (ext_bus_grant_n),
      .port_drive_en     (port_drive_en),
      .a                 (a)
   );
   // core requests outrank the outside master; reset leaves the engine idle and hold_bus low
   assign a.int_pending = req_valid || (state != EPBG_IDLE);
   assign a.idle        = (state == EPBG_IDLE);
   assign a.hold_bus    = hold_bus;

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         din_s1 <= 16'h0000;
         din_s2 <= 16'h0000;
      end else begin
         rdy_s1 <= ext_ready;
         rdy_s2 <= rdy_s1;
         din_s1 <= ext_data_in;
         din_s2 <= din_s1;
      end
   end

   // ==========================================================
   // configuration registers
   genvar gi;
   generate
      for (gi = 0; gi < `EPBG_NUM_SPACES; gi++) begin : g_cfg
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               cfg[gi] <= `EPBG_CFG_RST;
            end else if (reg_wr && reg_addr == 8'(`EPBG_OFF_CFG + `EPBG_REG_STEP * gi)) begin
               cfg[gi] <= reg_wdata;
            end
         end
         assign pol_vec[gi] = cfg[gi][`EPBG_F_POL];
      end
      for (gi = 0; gi < `EPBG_NUM_BANKS; gi++) begin : g_start
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               start_pg[8*gi +: 8] <= 8'(`EPBG_START_RST >> (8 * gi));
            end else if (reg_wr && reg_addr == 8'(`EPBG_OFF_START + `EPBG_REG_STEP * gi)) begin
               start_pg[8*gi +: 8] <= reg_wdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         excl <= 1'b0;
      end else if (reg_wr && reg_addr == `EPBG_OFF_CTRL) begin
         excl <= reg_wdata[`EPBG_CTRL_EXCL];
      end
   end

   always_comb begin
      rd_mux = 16'h0000;
      for (int i = 0; i < `EPBG_NUM_SPACES; i++) begin
         if (reg_addr == 8'(`EPBG_OFF_CFG + `EPBG_REG_STEP * i)) rd_mux = cfg[i];
      end
      for (int i = 0; i < `EPBG_NUM_BANKS; i++) begin
         if (reg_addr == 8'(`EPBG_OFF_START + `EPBG_REG_STEP * i)) rd_mux = {8'h00, start_pg[8*i +: 8]};
      end
      if (reg_addr == `EPBG_OFF_CTRL) rd_mux = {15'h0000, excl};
      if (reg_addr == `EPBG_OFF_STATUS) rd_mux = {11'h000, hold_bus, ~grant_hang_n, a.granted, state};
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ==========================================================
   // request decode and strobe timing
   assign req_tgt = decode_space(req_space, req_page, start_pg);
   // a new access waits until the port is ours again, drivers included, so it never fights the master
   assign bus_away = a.granted || !port_drive_en;
   assign go      = req_valid && !req_ack && (state == EPBG_IDLE) && !bus_away;
   assign base    = (req_tgt == `EPBG_T_IO) ? {2'h0, req_page, req_offset[9:0]} : {req_page[3:0], req_offset};
   // physical address scales with beats per word
   assign phys    = (last_beat == 2'h2) ? base + (base << 1) : (last_beat == 2'h1) ? base << 1 : base;
   assign last_beat = cfg[req_tgt][`EPBG_F_WIDE] ? {1'b0, req_wide} : (req_wide ? 2'h2 : 2'h1);
   assign div_lim = 3'((4'h1 << cur[`EPBG_F_DIV]) - 4'h1);
   assign tick    = (div_cnt == div_lim);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= 3'h0;
      end else if (state == EPBG_IDLE || tick) begin
         div_cnt <= 3'h0;
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end

   // ==========================================================
   // access engine
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state        <= EPBG_IDLE;
         cur          <= `EPBG_CFG_RST;
         tgt          <= `EPBG_T_NONE;
         beat         <= 2'h0;
         cnt          <= 4'h0;
         is_wr        <= 1'b0;
         wbuf         <= 24'h000000;
         rbuf         <= 24'h000000;
         ext_addr     <= 20'h00000;
         ext_data_out <= 16'h0000;
         ext_data_oe  <= 1'b0;
         ext_rd_n     <= 1'b1;
         ext_wr_n     <= 1'b1;
         chain_q      <= 1'b0;
         resp_rdata   <= 24'h000000;
      end else begin
         case (state)
            EPBG_IDLE: begin
               if (go && req_tgt != `EPBG_T_NONE) begin
                  state        <= EPBG_STROBE;
                  cur          <= cfg[req_tgt];
                  tgt          <= req_tgt;
                  beat         <= 2'h0;
                  is_wr        <= req_write;
                  wbuf         <= req_wdata;
                  rbuf         <= 24'h000000;
                  chain_q      <= req_chain && (req_chain_rd || excl);
                  cnt          <= req_write ? cfg[req_tgt][`EPBG_F_WWAIT] : cfg[req_tgt][`EPBG_F_RWAIT];
                  ext_addr     <= phys;
                  ext_data_out <= lane(req_wdata, 2'h0, cfg[req_tgt][`EPBG_F_WIDE]);
                  ext_data_oe  <= req_write;
                  ext_rd_n     <= req_write;
                  ext_wr_n     <= ~req_write;
               end
            end
            EPBG_STROBE: begin
               if (tick) begin
                  if (cnt != 4'h0) begin
                     cnt <= cnt - 4'h1;
                  end else if (!cur[`EPBG_F_ACKMODE] || rdy_s2) begin
                     ext_rd_n <= 1'b1;
                     ext_wr_n <= 1'b1;
                     cnt      <= {3'h0, is_wr & cur[`EPBG_F_WHOLD]};
                     state    <= EPBG_HOLD;
                     if (!is_wr) begin
                        if (cur[`EPBG_F_WIDE] && beat != 2'h0) rbuf[23:16] <= din_s2[7:0];
                        else if (cur[`EPBG_F_WIDE]) rbuf[15:0] <= din_s2;
                        else rbuf[{beat, 3'h0} +: 8] <= din_s2[7:0];
                     end
                  end
               end
            end
            EPBG_HOLD: begin
               if (tick) begin
                  if (cnt != 4'h0) begin
                     cnt <= cnt - 4'h1;
                  end else begin
                     ext_data_oe <= 1'b0;
                     state       <= EPBG_NEXT;
                  end
               end
            end
            EPBG_NEXT: begin
               if (beat == last_beat_q()) begin
                  resp_rdata <= rbuf;
                  state      <= EPBG_IDLE;
               end else begin
                  beat         <= beat + 2'h1;
                  ext_addr     <= ext_addr + 20'h00001;
                  ext_data_out <= lane(wbuf, beat + 2'h1, cur[`EPBG_F_WIDE]);
                  ext_data_oe  <= is_wr;
                  ext_rd_n     <= is_wr;
                  ext_wr_n     <= ~is_wr;
                  cnt          <= is_wr ? cur[`EPBG_F_WWAIT] : cur[`EPBG_F_RWAIT];
                  state        <= EPBG_STROBE;
               end
            end
            default: state <= EPBG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wide_q <= 1'b0;
      end else if (go) begin
         wide_q <= req_wide;
      end
   end

   // ==========================================================
   // handshake pulses, lock between chained accesses, hang flag
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         req_ack    <= 1'b0;
         resp_valid <= 1'b0;
         resp_err   <= 1'b0;
      end else begin
         req_ack    <= go;
         resp_err   <= go && (req_tgt == `EPBG_T_NONE);
         resp_valid <= (go && req_tgt == `EPBG_T_NONE) || (state == EPBG_NEXT && beat == last_beat_q());
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold_bus <= 1'b0;
      end else if (go) begin
         hold_bus <= 1'b0;
      end else if (state == EPBG_NEXT && beat == last_beat_q()) begin
         hold_bus <= chain_q;
      end else if (!req_valid && !req_ack) begin
         hold_bus <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         grant_hang_n <= 1'b1;
      end else begin
         grant_hang_n <= ~(req_valid && !req_ack && bus_away && req_tgt != `EPBG_T_NONE);
      end
   end

   // ==========================================================
   // space strobes, each with its own polarity
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strobe_on <= 6'h00;
      end else if (go && req_tgt != `EPBG_T_NONE) begin
         strobe_on <= 6'h01 << req_tgt;
      end else if (state == EPBG_NEXT && beat == last_beat_q()) begin
         strobe_on <= 6'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strobe_pin <= 6'h3F;
      end else if (go && req_tgt != `EPBG_T_NONE) begin
         strobe_pin <= ~((6'h01 << req_tgt) ^ pol_vec);
      end else if (state == EPBG_IDLE || (state == EPBG_NEXT && beat == last_beat_q())) begin
         strobe_pin <= ~pol_vec;
      end
   end
   assign bank_strobe_n       = strobe_pin[3:0];
   assign io_space_strobe_n   = strobe_pin[`EPBG_T_IO];
   assign boot_space_strobe_n = strobe_pin[`EPBG_T_BOOT];

   // ==========================================================
   // checks
   property p_strobe_one;
      @(posedge clk_sys) disable iff (!rstn)
      $onehot0(strobe_on) && (state == EPBG_IDLE || strobe_on == (6'h01 << tgt));
   endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("more than one space strobe");
   property p_io_onchip;
      @(posedge clk_sys) disable iff (!rstn)
      go && req_space == EPBG_SP_IO && req_page < `EPBG_IO_FIRST |=> resp_err && resp_valid && !strobe_on[4];
   endproperty
   a_io_onchip: assert property (p_io_onchip) else $error("on-chip I/O page went out");
   property p_stall;
      @(posedge clk_sys) disable iff (!rstn)
      a.granted && state == EPBG_IDLE |=> state == EPBG_IDLE;
   endproperty
   a_stall: assert property (p_stall) else $error("access started while granted away");
   property p_hang;
      @(posedge clk_sys) disable iff (!rstn)
      a.granted && req_valid && !req_ack && req_tgt != `EPBG_T_NONE |=> !grant_hang_n;
   endproperty
   a_hang: assert property (p_hang) else $error("grant hang not raised");
   sequence s_start_read_pair;
      go && req_tgt != `EPBG_T_NONE && req_chain && req_chain_rd;
   endsequence
   property p_read_pair;
      @(posedge clk_sys) disable iff (!rstn)
      s_start_read_pair |=> chain_q;
   endproperty
   a_read_pair: assert property (p_read_pair) else $error("read pair not locked");
endmodule // epbg_top

// >>> bench/epbg_far.sv
// far side: external memory answering reads, plus an outside bus master
`timescale 1ns/1ps
module epbg_far (
   input  wire logic        clk_sys,
   input  wire logic [19:0] ext_addr,
   input  wire logic        ext_rd_n,
   input  wire logic        port_drive_en,
   input  wire logic        mst_want,
   output logic [15:0]      ext_data_in,
   output logic             ext_ready,
   output logic             ext_bus_request_n
);
   logic [15:0] last = 16'h0000;
   always @(posedge clk_sys) last <= ext_data_in;
   // an idle bus toggles every cycle so a stale word never passes for data
   assign ext_data_in = (!ext_rd_n && port_drive_en) ? (ext_addr[15:0] ^ 16'h5A5A) : ~last;
   assign ext_ready = 1'b1;
   // master holds its request for as long as it uses the bus, drops it when done
   assign ext_bus_request_n = !mst_want;
endmodule // epbg_far

// >>> bench/tb_epbg_top.sv
// self-checking bench of the off-chip access unit
`timescale 1ns/1ps
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_epbg_top;
   import epbg_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
   logic req_write = 1'b0, req_wide = 1'b0, req_chain = 1'b0, req_chain_rd = 1'b0, mst_want = 1'b0;
   logic [7:0] reg_addr = 8'h00, req_page = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, req_offset = 16'h0123, reg_rdata, ext_data_out, ext_data_in;
   logic [23:0] req_wdata = 24'h000000, resp_rdata;
   logic [19:0] ext_addr;
   logic [3:0] bank_strobe_n;
   logic req_ack, resp_valid, resp_err, ext_data_oe, ext_rd_n, ext_wr_n, port_drive_en, ext_ready;
   logic io_space_strobe_n, boot_space_strobe_n, ext_bus_request_n, ext_bus_grant_n, grant_hang_n;
   epbg_space_e req_space = EPBG_SP_MEM;
   int compares = 0, failures = 0;
   epbg_top DUT (.*);
   epbg_far FAR (.*);
   always #25 clk_sys = ~clk_sys;
   // ==========================================================
   // bus tasks
   task automatic rw(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      if (w) reg_wr <= 1'b1; else reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      if (!w) `CHK("reg_rdata", d, reg_rdata)
   endtask
   // reads one word and checks error flag, strobes at the first beat, and data
   task automatic acc(input epbg_space_e s, input logic [7:0] p, input logic w, input logic [5:0] stb,
                      input logic err, input logic [23:0] e);
      int n = 0;
      @(posedge clk_sys);
      req_space <= s;
      req_page <= p;
      req_wide <= w;
      req_valid <= 1'b1;
      do @(negedge clk_sys); while (req_ack !== 1'b1 && ++n < 400);
      `CHK("resp_err", err, resp_err)
      @(posedge clk_sys);
      req_valid <= 1'b0;
      if (!err) begin
         do @(negedge clk_sys); while (ext_rd_n !== 1'b0 && ++n < 400);
         `CHK("strobes", stb, {boot_space_strobe_n, io_space_strobe_n, bank_strobe_n})
         do @(negedge clk_sys); while (resp_valid !== 1'b1 && ++n < 400);
         `CHK("resp_rdata", e, resp_rdata)
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      rw(0, 8'h00, 16'h2077);
      rw(0, 8'h14, 16'h2077);
      for (int i = 0; i < 4; i++) rw(0, 8'h18 + 8'(4 * i), {8'h00, 8'(i == 0 ? 1 : 64 * i)});
      rw(0, 8'h40, 16'h0000);
      $display("done regs");
   endtask
   task automatic t_decode;
      logic [7:0] pg[4] = '{8'h3F, 8'h40, 8'hBF, 8'hFE};
      for (int i = 0; i < 4; i++) acc(EPBG_SP_MEM, pg[i], 0, ~(6'h01 << i), 0, 24'h005B79);
      acc(EPBG_SP_MEM, 8'h00, 0, 6'h3F, 1, 24'h0);
      acc(EPBG_SP_MEM, 8'hFF, 0, 6'h3F, 1, 24'h0);
      acc(EPBG_SP_IO, 8'h1F, 0, 6'h3F, 1, 24'h0);
      acc(EPBG_SP_IO, 8'h20, 0, 6'h2F, 0, 24'h00DB79);
      acc(EPBG_SP_BOOT, 8'h03, 0, 6'h1F, 0, 24'h005B79);
      $display("done decode");
   endtask
   task automatic t_pack;
      acc(EPBG_SP_MEM, 8'h01, 1, 6'h3E, 0, 24'h1D581C);
      rw(1, 8'h00, 16'h0077);
      acc(EPBG_SP_MEM, 8'h01, 0, 6'h3E, 0, 24'h001D1C);
      rw(1, 8'h00, 16'h2077);
      $display("done pack");
   endtask
   task automatic t_grant;
      int n = 0;
      @(posedge clk_sys);
      mst_want <= 1'b1;
      do @(negedge clk_sys); while (ext_bus_grant_n !== 1'b0 && ++n < 50);
      `CHK("grant_delay", 5, n)
      `CHK("drive_en", 1'b0, port_drive_en)
      fork
         acc(EPBG_SP_MEM, 8'h40, 0, 6'h3D, 0, 24'h005B79);
         begin
            repeat (8) @(negedge clk_sys);
            `CHK("hang", 1'b0, grant_hang_n)
            `CHK("held", 1'b0, port_drive_en)
            @(posedge clk_sys);
            mst_want <= 1'b0;
         end
      join
      `CHK("grant_off", 1'b1, ext_bus_grant_n)
      $display("done grant");
   endtask
   task automatic t_rst_grant;
      int n = 0;
      @(posedge clk_sys);
      rstn <= 1'b0;
      mst_want <= 1'b1;
      do @(negedge clk_sys); while (ext_bus_grant_n !== 1'b0 && ++n < 50);
      `CHK("grant_in_reset", 5, n)
      @(posedge clk_sys);
      mst_want <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      acc(EPBG_SP_MEM, 8'h40, 0, 6'h3D, 0, 24'h005B79);
      $display("done reset grant");
   endtask
   task automatic t_write;
      int n = 0;
      @(posedge clk_sys);
      req_write <= 1'b1;
      req_wdata <= 24'hA5C3E1;
      req_space <= EPBG_SP_MEM;
      req_page <= 8'h40;
      req_valid <= 1'b1;
      do @(negedge clk_sys); while (req_ack !== 1'b1 && ++n < 400);
      `CHK("wr_n", 1'b0, ext_wr_n)
      `CHK("data_out", 16'hC3E1, ext_data_out)
      `CHK("data_oe", 1'b1, ext_data_oe)
      `CHK("wr_addr", 20'h00123, ext_addr)
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_write <= 1'b0;
      n = 1;
      @(negedge clk_sys);
      while (ext_wr_n === 1'b0 && n < 400) begin
         n++;
         @(negedge clk_sys);
      end
      `CHK("wr_ticks", 8, n)
      do @(negedge clk_sys); while (resp_valid !== 1'b1 && ++n < 400);
      `CHK("oe_off", 1'b0, ext_data_oe)
      $display("done write");
   endtask
   task automatic t_chain;
      int n = 0;
      @(posedge clk_sys);
      req_chain <= 1'b1;
      req_chain_rd <= 1'b1;
      mst_want <= 1'b1;
      // a grant between the two reads would stall the second one for good
      acc(EPBG_SP_MEM, 8'h40, 0, 6'h3D, 0, 24'h005B79);
      acc(EPBG_SP_MEM, 8'h41, 0, 6'h3D, 0, 24'h005B79);
      @(posedge clk_sys);
      req_chain <= 1'b0;
      req_chain_rd <= 1'b0;
      do @(negedge clk_sys); while (ext_bus_grant_n !== 1'b0 && ++n < 50);
      `CHK("pair_grant", 1'b0, ext_bus_grant_n)
      @(posedge clk_sys);
      mst_want <= 1'b0;
      do @(negedge clk_sys); while (port_drive_en !== 1'b1 && ++n < 50);
      `CHK("pair_release", 1'b1, ext_bus_grant_n)
      $display("done chain");
   endtask
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // the full run needs well under 1500 cycles
   initial begin
      #(50 * 20000);
      failures++;
      end_sim;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      por_n <= 1'b1;
      t_regs;
      t_decode;
      t_pack;
      t_write;
      t_grant;
      t_chain;
      t_rst_grant;
      end_sim;
   end
endmodule // tb_epbg_top
